/* File: rtl/psq_irq_vector.sv */
// Fixed-priority interrupt vector encoder
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_irq_vector (
    input  wire logic [11:0] i_pending,
    output logic             o_any,
    output logic [12:0]      o_vector
);
    import psq_pkg::*;
    // Bit 0 is the enable-pin edge, highest priority; vector falls by one per source
    always_comb begin
        o_any    = 1'b0;
        o_vector = 13'h0000;
        for (int i = `PSQ_IRQ_SOURCES - 1; i >= 0; i--) begin
            if (i_pending[i]) begin
                o_any    = 1'b1;
                o_vector = `PSQ_VEC_CE - 13'(i);
            end
        end
    end
endmodule

/* File: rtl/psq_pkg.sv */
// Types shared by the program sequencer files
package psq_pkg;
    typedef enum logic [3:0] {
        PSQ_OP_NONE,
        PSQ_OP_SKIP,
        PSQ_OP_JUMP,
        PSQ_OP_CALL,
        PSQ_OP_JUMP_IND,
        PSQ_OP_CALL_IND,
        PSQ_OP_TABLE_FETCH,
        PSQ_OP_MONITOR_CALL,
        PSQ_OP_SUB_EXIT,
        PSQ_OP_EXIT_AND_SKIP,
        PSQ_OP_IRQ_EXIT,
        PSQ_OP_PUSH,
        PSQ_OP_POP
    } psq_op_type;

    typedef struct packed {
        logic       valid;
        psq_op_type op;
        logic [12:0] operand;
    } psq_instr_type;

    typedef struct packed {
        logic        seg;
        logic [12:0] pc;
    } psq_addr_type;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [3:0] addr;
        logic [3:0] wdata;
    } psq_reg_req_type;
endpackage

/* File: rtl/psq_regs.svh */
// Offsets, field positions, reset values and vectors of the program sequencer
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH
`define PSQ_PC_WIDTH          13
`define PSQ_SLOT_WIDTH        16
`define PSQ_SP_WIDTH          4
`define PSQ_SP_REG_ADDR       4'h1
`define PSQ_SP_RESET          4'hf
`define PSQ_SLOT_COUNT        15
`define PSQ_PC_RESET          13'h0000
`define PSQ_PAGE_HI           12
`define PSQ_PAGE_LO           11
`define PSQ_VEC_CE            13'h000c
`define PSQ_VEC_EXT0          13'h000b
`define PSQ_VEC_TIMER0        13'h0006
`define PSQ_VEC_SERIAL0       13'h0002
`define PSQ_IRQ_SOURCES       12
`endif

/* File: rtl/psq_return_stack.sv */
// Return slot storage, fifteen implemented slots
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_return_stack #(
    parameter int SLOTS = `PSQ_SLOT_COUNT,
    parameter int WIDTH = `PSQ_SLOT_WIDTH
) (
    input  wire logic             i_clock,
    input  wire logic             i_we,
    input  wire logic [3:0]       i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [3:0]       i_raddr,
    output logic [WIDTH-1:0]      o_rdata
);
    logic [WIDTH-1:0] slots [SLOTS];
    // Slot 15 has no storage; it reads as all ones, standing for undefined
    wire              read_hit = 32'(i_raddr) < SLOTS;

    always_ff @(posedge i_clock) begin
        if (i_we && 32'(i_waddr) < SLOTS) begin
            slots[i_waddr] <= i_wdata;
        end
    end
    assign o_rdata = read_hit ? slots[i_raddr] : {WIDTH{1'b1}};
endmodule

/* File: rtl/psq_sequencer.sv */
// Program counter, segment bit, stack pointer and next-address selection
`timescale 1ns/1ps
`include "psq_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module psq_sequencer (
    input  wire logic                     i_clock,
    input  wire logic                     i_nrst,
    input  wire logic                     i_reset_req,
    input  wire psq_pkg::psq_instr_type   i_instr,
    input  wire logic                     i_skip_taken,
    input  wire logic [11:0]              i_irq_pending,
    input  wire psq_pkg::psq_addr_type    i_indirect_pointer,
    input  wire psq_pkg::psq_reg_req_type i_reg,
    input  wire logic                     i_stack_reset_enable,
    input  wire logic [15:0]              i_rom_data,
    output psq_pkg::psq_addr_type         o_fetch_addr,
    output logic                          o_fetch_is_table,
    output logic [15:0]                   o_constant_buffer,
    output logic                          o_constant_valid,
    output logic [3:0]                    o_stack_pointer,
    output logic [3:0]                    o_reg_rdata,
    output psq_pkg::psq_addr_type         o_pop_data,
    output logic                          o_pop_valid,
    output logic                          o_irq_ack,
    output logic                          o_stack_reset
);
    import psq_pkg::*;

    typedef enum logic {PSQ_ST_RUN, PSQ_ST_TABLE} psq_state_type;

    ////////////////////////////////////////////////////////////////////////////
    // State
    psq_state_type state;
    psq_addr_type  pc_reg;
    psq_addr_type  table_ret;
    logic [3:0]    stack_pointer;
    logic          irq_any;
    logic [12:0]   irq_vector;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire           in_valid   = i_instr.valid && state == PSQ_ST_RUN;
    wire psq_op_type op       = i_instr.op;
    wire           take_irq   = (state == PSQ_ST_RUN) && irq_any;
    wire           do_exec    = in_valid && !take_irq;
    wire           is_save    = do_exec && (op == PSQ_OP_CALL || op == PSQ_OP_CALL_IND ||
                                            op == PSQ_OP_MONITOR_CALL || op == PSQ_OP_PUSH);
    wire           is_restore = do_exec && (op == PSQ_OP_SUB_EXIT || op == PSQ_OP_EXIT_AND_SKIP ||
                                            op == PSQ_OP_IRQ_EXIT || op == PSQ_OP_POP);
    wire           push_now   = is_save || take_irq;
    wire           table_end  = state == PSQ_ST_TABLE;
    wire           sw_write   = i_reg.we && i_reg.addr == `PSQ_SP_REG_ADDR;
    wire           restart    = i_reset_req || o_stack_reset;
    wire           overflow   = push_now && stack_pointer == 4'h0;
    wire           underflow  = is_restore && stack_pointer == 4'hf;

    // Call and table-fetch return addresses are the word after the current one
    wire [12:0]    pc_inc     = pc_reg.pc + 13'h0001;
    wire [12:0]    pc_skip    = pc_reg.pc + 13'h0002;
    wire [3:0]     sp_dec     = stack_pointer - 4'h1;
    wire [3:0]     sp_inc     = stack_pointer + 4'h1;
    wire [3:0]     slot_waddr = sp_dec;
    wire [15:0]    slot_rdata;
    wire psq_addr_type slot_addr = psq_addr_type'(slot_rdata[13:0]);
    wire psq_addr_type ret_addr  = '{seg: pc_reg.seg, pc: pc_inc};
    // Interrupt saves the dropped instruction's address so it runs after the exit
    wire [15:0]    slot_wdata = take_irq            ? {2'b00, pc_reg} :
                                (op == PSQ_OP_PUSH) ? {2'b00, i_indirect_pointer}
                                                    : {2'b00, ret_addr};
    // Monitor call entry: 3 upper bits, four zeros, 4 lower bits
    wire [12:0]    monitor_target = {2'b00, i_instr.operand[6:4], 4'h0, i_instr.operand[3:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Next address selection
    psq_addr_type next_pc;
    always_comb begin
        next_pc = pc_reg;
        if (table_end) begin
            next_pc = table_ret;
        end else if (take_irq) begin
            next_pc = '{seg: 1'b0, pc: irq_vector};
        end else if (do_exec) begin
            unique case (op)
                PSQ_OP_JUMP:          next_pc = '{seg: pc_reg.seg, pc: i_instr.operand};
                PSQ_OP_CALL:          next_pc = '{seg: pc_reg.seg, pc: {2'b00, i_instr.operand[10:0]}};
                PSQ_OP_JUMP_IND,
                PSQ_OP_CALL_IND:      next_pc = i_indirect_pointer;
                PSQ_OP_MONITOR_CALL:  next_pc = '{seg: 1'b1, pc: monitor_target};
                PSQ_OP_SUB_EXIT,
                PSQ_OP_IRQ_EXIT:      next_pc = slot_addr;
                PSQ_OP_EXIT_AND_SKIP: next_pc = '{seg: slot_addr.seg, pc: slot_addr.pc + 13'h0001};
                PSQ_OP_SKIP:          next_pc = '{seg: pc_reg.seg, pc: i_skip_taken ? pc_skip : pc_inc};
                PSQ_OP_TABLE_FETCH:   next_pc = pc_reg;
                default:              next_pc = '{seg: pc_reg.seg, pc: pc_inc};
            endcase
        end
    end

    // Table fetch leaves the stack pointer alone; its return address is kept in table_ret
    wire [3:0] next_sp = sw_write   ? i_reg.wdata :
                         push_now   ? sp_dec :
                         is_restore ? sp_inc :
                         stack_pointer;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge i_clock) begin
        if (!i_nrst || i_reset_req || o_stack_reset) begin
            pc_reg        <= '{seg: 1'b0, pc: `PSQ_PC_RESET};
            stack_pointer <= `PSQ_SP_RESET;
            state         <= PSQ_ST_RUN;
            table_ret     <= '{seg: 1'b0, pc: `PSQ_PC_RESET};
        end else begin
            pc_reg        <= next_pc;
            stack_pointer <= next_sp;
            if (do_exec && op == PSQ_OP_TABLE_FETCH) begin
                state     <= PSQ_ST_TABLE;
                table_ret <= ret_addr;
            end else begin
                state     <= PSQ_ST_RUN;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_fetch_addr      <= '{seg: 1'b0, pc: `PSQ_PC_RESET};
            o_fetch_is_table  <= 1'b0;
            o_constant_buffer <= 16'h0000;
            o_constant_valid  <= 1'b0;
            o_stack_pointer   <= `PSQ_SP_RESET;
            o_reg_rdata       <= 4'h0;
            o_pop_data        <= '{seg: 1'b0, pc: 13'h0000};
            o_pop_valid       <= 1'b0;
            o_irq_ack         <= 1'b0;
            o_stack_reset     <= 1'b0;
        end else begin
            // Soft resets must show on the fetch address in the same edge as the counter
            if (restart) begin
                o_fetch_addr    <= '{seg: 1'b0, pc: `PSQ_PC_RESET};
                o_stack_pointer <= `PSQ_SP_RESET;
            end else begin
                // Table fetch drives the pointer as the fetch address for one word
                o_fetch_addr    <= (do_exec && op == PSQ_OP_TABLE_FETCH) ? i_indirect_pointer : next_pc;
                o_stack_pointer <= next_sp;
            end
            o_fetch_is_table  <= !restart && do_exec && op == PSQ_OP_TABLE_FETCH;
            o_constant_valid  <= o_fetch_is_table;
            if (o_fetch_is_table) begin
                o_constant_buffer <= i_rom_data;
            end
            o_reg_rdata       <= (i_reg.re && i_reg.addr == `PSQ_SP_REG_ADDR) ? stack_pointer : 4'h0;
            o_pop_valid       <= do_exec && op == PSQ_OP_POP;
            o_pop_data        <= slot_addr;
            o_irq_ack         <= take_irq;
            // Reset cannot be self-sustaining: it is a single pulse
            o_stack_reset     <= !o_stack_reset && i_stack_reset_enable && (overflow || underflow);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Leaf blocks
    psq_irq_vector u_vector (
        .i_pending (i_irq_pending),
        .o_any     (irq_any),
        .o_vector  (irq_vector)
    );

    psq_return_stack u_stack (
        .i_clock (i_clock),
        .i_we    (push_now && i_nrst && !restart),
        .i_waddr (slot_waddr),
        .i_wdata (slot_wdata),
        .i_raddr (stack_pointer),
        .o_rdata (slot_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence seq_call_taken;
        do_exec && op == PSQ_OP_CALL && !i_reset_req && !o_stack_reset && !sw_write;
    endsequence
    sequence seq_jump_taken;
        do_exec && op == PSQ_OP_JUMP && !i_reset_req && !o_stack_reset;
    endsequence

    call_page0_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        seq_call_taken |=> pc_reg.pc[12:11] == 2'b00 && pc_reg.seg == $past(pc_reg.seg))
        else $error("direct call left page 0 or segment");
    jump_keeps_seg_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        seq_jump_taken |=> pc_reg.pc == $past(i_instr.operand) && pc_reg.seg == $past(pc_reg.seg))
        else $error("direct jump target or segment wrong");
    call_push_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        seq_call_taken |=> stack_pointer == $past(stack_pointer) - 4'h1)
        else $error("call did not decrement stack pointer");
    irq_vector_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        take_irq && !i_reset_req && !o_stack_reset
        |=> !pc_reg.seg && pc_reg.pc != 13'h0000 && pc_reg.pc <= `PSQ_VEC_CE)
        else $error("interrupt vector out of range");
    seg_stable_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        do_exec && (op == PSQ_OP_NONE || op == PSQ_OP_SKIP) && !i_reset_req && !o_stack_reset
        |=> pc_reg.seg == $past(pc_reg.seg))
        else $error("segment bit moved on plain instruction");
    inc_wrap_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        do_exec && op == PSQ_OP_NONE && pc_reg.pc == 13'h1fff && !i_reset_req && !o_stack_reset
        |=> pc_reg.pc == 13'h0000)
        else $error("increment did not wrap in segment");
    monitor_seg_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        do_exec && op == PSQ_OP_MONITOR_CALL && !i_reset_req && !o_stack_reset
        |=> pc_reg.seg && pc_reg.pc[12:11] == 2'b00 && pc_reg.pc[7:4] == 4'h0)
        else $error("monitor call target malformed");
    table_return_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_fetch_is_table |=> o_constant_valid && o_constant_buffer == $past(i_rom_data))
        else $error("constant buffer not loaded");
    reset_clear_a: assert property (@(posedge i_clock)
        !i_nrst |=> pc_reg == '0)
        else $error("reset did not clear counter");
    sw_write_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        sw_write && !i_reset_req && !o_stack_reset |=> stack_pointer == $past(i_reg.wdata))
        else $error("stack pointer write lost");
    exit_load_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        do_exec && (op == PSQ_OP_SUB_EXIT || op == PSQ_OP_IRQ_EXIT) && !restart
        |=> pc_reg == $past(slot_addr))
        else $error("exit did not load return slot");
    restore_inc_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        is_restore && !sw_write && !restart |=> stack_pointer == $past(stack_pointer) + 4'h1)
        else $error("restore did not increment stack pointer");
    soft_reset_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        restart |=> pc_reg == '0 && stack_pointer == `PSQ_SP_RESET && o_fetch_addr == '0)
        else $error("soft reset did not clear counter");
endmodule

/* File: tb/psq_rom_model.sv */
// Program memory model answering the sequencer's fetch address
`timescale 1ns/1ps
module psq_rom_model (
    input  wire psq_pkg::psq_addr_type i_addr,
    output logic [15:0]                o_data
);
    import psq_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // One word per address, content derived from the address itself
    // Pattern keeps segment bit visible so a wrong segment shows in the data
    assign o_data = {2'b10, i_addr};
endmodule

/* File: tb/psq_sequencer_tb.sv */
// Self-checking bench for the program sequencer
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_sequencer_tb;
    import psq_pkg::*;
    logic            i_clock = 1'b0;
    logic            i_nrst = 1'b0;
    logic            i_reset_req = 1'b0;
    psq_instr_type   instr = '0;
    logic            skip = 1'b0;
    logic [11:0]     pending = 12'h000;
    psq_addr_type    ptr = '0;
    psq_reg_req_type reg_req = '0;
    logic            rst_en = 1'b0;
    logic [15:0]     rom_data;
    psq_addr_type    fetch_addr;
    psq_addr_type    pop_data;
    psq_addr_type    pop_hold;
    logic            is_table, cvalid, pop_valid, irq_ack, stack_rst;
    logic [15:0]     cbuf;
    logic [3:0]      sp, rdata;
    logic            seen_pop, seen_ack, seen_rst;
    int              err_count = 0;
    int              cmp_count = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #2 i_clock = ~i_clock;
    psq_sequencer psq_sequencer_inst (
        .i_clock              (i_clock),
        .i_nrst               (i_nrst),
        .i_reset_req          (i_reset_req),
        .i_instr              (instr),
        .i_skip_taken         (skip),
        .i_irq_pending        (pending),
        .i_indirect_pointer   (ptr),
        .i_reg                (reg_req),
        .i_stack_reset_enable (rst_en),
        .i_rom_data           (rom_data),
        .o_fetch_addr         (fetch_addr),
        .o_fetch_is_table     (is_table),
        .o_constant_buffer    (cbuf),
        .o_constant_valid     (cvalid),
        .o_stack_pointer      (sp),
        .o_reg_rdata          (rdata),
        .o_pop_data           (pop_data),
        .o_pop_valid          (pop_valid),
        .o_irq_ack            (irq_ack),
        .o_stack_reset        (stack_rst)
    );
    psq_rom_model psq_rom_model_inst (
        .i_addr (fetch_addr),
        .o_data (rom_data)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic chk_pc(input logic seg, input logic [12:0] pc);
        chk("fetch_addr", {2'b00, seg, pc}, {2'b00, fetch_addr});
    endtask
    task automatic chk_sp(input logic [3:0] exp);
        chk("stack_pointer", {12'h000, exp}, {12'h000, sp});
    endtask
    // One-cycle instruction, then an idle cycle so the result has settled
    task automatic op(input psq_op_type o, input logic [12:0] v);
        @(negedge i_clock);
        instr = '{valid: 1'b1, op: o, operand: v};
        @(negedge i_clock);
        instr.valid = 1'b0;
        seen_pop = pop_valid;
        pop_hold = pop_data;
        seen_ack = irq_ack;
        seen_rst = stack_rst;
        @(negedge i_clock);
        seen_pop |= pop_valid;
        seen_ack |= irq_ack;
        seen_rst |= stack_rst;
    endtask
    task automatic reg_access(input logic we, input logic [3:0] a, input logic [3:0] d);
        @(negedge i_clock);
        reg_req = '{we: we, re: ~we, addr: a, wdata: d};
        @(negedge i_clock);
        reg_req = '0;
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Run is about 150 cycles; 2000 cycles means a hang
    initial begin
        #8000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (3) @(negedge i_clock);
        i_nrst = 1'b1;
        @(negedge i_clock);
        chk_pc(1'b0, 13'h0000);
        chk_sp(`PSQ_SP_RESET);
        op(PSQ_OP_NONE, 13'h1555);
        chk_pc(1'b0, 13'h0001);
        skip = 1'b1;
        op(PSQ_OP_SKIP, 13'h0000);
        chk_pc(1'b0, 13'h0003);
        skip = 1'b0;
        op(PSQ_OP_SKIP, 13'h0000);
        chk_pc(1'b0, 13'h0004);
        op(PSQ_OP_JUMP, 13'h1fff);
        chk_pc(1'b0, 13'h1fff);
        op(PSQ_OP_NONE, 13'h0000);
        chk_pc(1'b0, 13'h0000);
        ptr = '{seg: 1'b1, pc: 13'h1234};
        op(PSQ_OP_JUMP_IND, 13'h0000);
        chk_pc(1'b1, 13'h1234);
        op(PSQ_OP_JUMP, 13'h0abc);
        chk_pc(1'b1, 13'h0abc);
        op(PSQ_OP_CALL, 13'h1fff);
        chk_pc(1'b1, 13'h07ff);
        chk_sp(4'he);
        op(PSQ_OP_SUB_EXIT, 13'h0000);
        chk_pc(1'b1, 13'h0abd);
        chk_sp(4'hf);
        ptr = '{seg: 1'b0, pc: 13'h0100};
        op(PSQ_OP_JUMP_IND, 13'h0000);
        chk_pc(1'b0, 13'h0100);
        op(PSQ_OP_MONITOR_CALL, 13'h005a);
        chk_pc(1'b1, 13'h050a);
        chk_sp(4'he);
        op(PSQ_OP_SUB_EXIT, 13'h0000);
        chk_pc(1'b0, 13'h0101);
        ptr = '{seg: 1'b1, pc: 13'h0200};
        op(PSQ_OP_CALL_IND, 13'h0000);
        chk_pc(1'b1, 13'h0200);
        op(PSQ_OP_EXIT_AND_SKIP, 13'h0000);
        chk_pc(1'b0, 13'h0103);
        ptr = '{seg: 1'b1, pc: 13'h0300};
        @(negedge i_clock);
        instr = '{valid: 1'b1, op: PSQ_OP_TABLE_FETCH, operand: 13'h0000};
        @(negedge i_clock);
        instr.valid = 1'b0;
        chk_pc(1'b1, 13'h0300);
        chk("is_table", 16'h0001, {15'h0000, is_table});
        @(negedge i_clock);
        chk("constant_valid", 16'h0001, {15'h0000, cvalid});
        chk("constant_buffer", 16'ha300, cbuf);
        chk_pc(1'b0, 13'h0104);
        // Lower-priority sources stay pending beside the winner
        for (int k = 0; k < 12; k++) begin
            @(negedge i_clock);
            pending = 12'hfff << k;
            @(negedge i_clock);
            pending = 12'h000;
            seen_ack = irq_ack;
            @(negedge i_clock);
            chk("irq_ack", 16'h0001, {15'h0000, seen_ack | irq_ack});
            chk_pc(1'b0, `PSQ_VEC_CE - 13'(k));
            chk_sp(4'he);
            op(PSQ_OP_IRQ_EXIT, 13'h0000);
            chk_sp(4'hf);
            chk_pc(1'b0, 13'h0104);
        end
        reg_access(1'b1, 4'h1, 4'h5);
        reg_access(1'b0, 4'h1, 4'h0);
        chk("reg_rdata", 16'h0005, {12'h000, rdata});
        chk_sp(4'h5);
        reg_access(1'b0, 4'h2, 4'h0);
        chk("reg_rdata", 16'h0000, {12'h000, rdata});
        ptr = '{seg: 1'b1, pc: 13'h0777};
        op(PSQ_OP_PUSH, 13'h0000);
        chk_sp(4'h4);
        ptr = '0;
        op(PSQ_OP_POP, 13'h0000);
        chk("pop_valid", 16'h0001, {15'h0000, seen_pop});
        chk("pop_data", 16'h2777, {2'b00, pop_hold});
        chk_sp(4'h5);
        reg_access(1'b1, 4'h1, 4'h0);
        rst_en = 1'b1;
        op(PSQ_OP_CALL, 13'h0010);
        chk("stack_reset", 16'h0001, {15'h0000, seen_rst});
        chk_pc(1'b0, 13'h0000);
        chk_sp(`PSQ_SP_RESET);
        rst_en = 1'b0;
        op(PSQ_OP_JUMP, 13'h0555);
        @(negedge i_clock);
        i_reset_req = 1'b1;
        @(negedge i_clock);
        i_reset_req = 1'b0;
        @(negedge i_clock);
        chk_pc(1'b0, 13'h0000);
        chk_sp(`PSQ_SP_RESET);
        // Exit with an empty stack reads the unstored slot and must trip the reset
        rst_en = 1'b1;
        op(PSQ_OP_SUB_EXIT, 13'h0000);
        chk("stack_reset", 16'h0001, {15'h0000, seen_rst});
        chk_pc(1'b0, 13'h0000);
        chk_sp(`PSQ_SP_RESET);
        rst_en = 1'b0;
        finish_test;
    end
endmodule
